// *** design/ufh_pkg.sv ***
// Package: register map, field positions and reset values for the block
package ufh_pkg;
    // Offsets are not all multiples of four: kept as indices
    localparam logic [27:0] UFH_IDX_NAK_MASK = 28'hffffe03;
    localparam logic [31:0] UFH_IDX_SIE_CTRL = 32'hfffffe04;
    // Register indices (low address bits) used by the bus decoder
    localparam logic [3:0] UFH_A_NAK_MASK = 4'h3;
    localparam logic [3:0] UFH_A_SIE_CTRL = 4'h4;
    localparam logic [3:0] UFH_A_EP_NAK = 4'h5;
    localparam logic [3:0] UFH_A_IN1_CTRL = 4'h6;
    localparam logic [3:0] UFH_A_IN1_STAT = 4'h7;
    // Field positions
    localparam int UFH_B_OUT2 = 3;
    localparam int UFH_B_OUT1 = 2;
    localparam int UFH_B_IN1 = 0;
    localparam int UFH_B_STALL = 3;
    localparam int UFH_B_RESUME = 0;
    // Control register of endpoint 1 IN
    localparam int UFH_B_DEND = 0;
    localparam int UFH_B_DMA_END_EN = 1;
    localparam int UFH_B_DMA_EN = 2;
    localparam int UFH_B_DMA_UNMASK = 3;
    localparam int UFH_B_FIFO_CLR = 4;
    localparam int UFH_B_RWAKE = 5;
    // Reset values and bank size
    localparam logic [7:0] UFH_RST_REG = 8'h00;
    localparam int UFH_BANK_BYTES = 64;
    localparam logic [6:0] UFH_CNT_ZERO = 7'h00;
endpackage

// *** design/ufh_bank_ctr.sv ***
// File: one byte counter of a FIFO bank
`timescale 1ns/1ns
module ufh_bank_ctr
    import ufh_pkg::*;
#(
    parameter int DEPTH = UFH_BANK_BYTES
) (
    input wire logic i_core_clk, // Clock
    input wire logic i_arst_n, // Async reset
    input wire logic i_clr, // Empty the bank
    input wire logic i_inc, // One byte written
    input wire logic i_load, // Take a count
    input wire logic [6:0] i_load_val, // Count to take
    input wire logic i_dec, // One byte sent
    output logic [6:0] o_cnt, // Byte count
    output logic o_full // Bank full
);
    typedef struct packed {
        logic [6:0] cnt;
    } ufh_ctr_t;
    ufh_ctr_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (i_clr) begin
            st_d.cnt = UFH_CNT_ZERO;
        end else if (i_load) begin
            st_d.cnt = i_load_val;
        end else if (i_inc && st_q.cnt != 7'(DEPTH)) begin
            st_d.cnt = st_q.cnt + 7'h01;
        end else if (i_dec && st_q.cnt != UFH_CNT_ZERO) begin
            st_d.cnt = st_q.cnt - 7'h01;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_cnt = st_q.cnt;
    assign o_full = (st_q.cnt == 7'(DEPTH));
endmodule

// *** design/ufh_ctrl.sv ***
// File: NAK, STALL and Resume handshake control with Avalon-MM registers
`timescale 1ns/1ns
module ufh_ctrl
    import ufh_pkg::*;
(
    input wire logic i_core_clk, // 125 MHz clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic [3:0] avs_address, // Word index
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Wait
    input wire logic i_cpu_wr, // Byte write into bulk_in1_fifo
    input wire logic i_dma_wr, // Byte written by DMA
    input wire logic i_dma_tc, // DMA terminal count
    input wire logic i_in_token, // IN token for endpoint 1
    input wire logic i_tx_byte, // One byte sent
    input wire logic i_tx_done, // Packet sent and acknowledged
    input wire logic i_setup_token, // SETUP token on endpoint 0
    input wire logic i_bad_wvalue, // Unsupported wValue seen
    input wire logic i_auto_overrun, // Auto request overrun
    input wire logic i_fw_req_active, // Firmware-executed request busy
    input wire logic i_ep0_wr, // Write to ep0_write_fifo
    output logic o_dma_req, // DMA request
    output logic o_in1_send, // Start sending endpoint 1 data
    output logic o_in1_nak, // Answer NAK on endpoint 1
    output logic o_ep0_stall, // Answer STALL on endpoint 0
    output logic o_resume, // Drive Resume on bus
    output logic o_out1_nak, // bulk_out1_nak_ctrl
    output logic o_out2_nak // bulk_out2_nak_ctrl
);
    typedef struct packed {
        logic [7:0] nak_mask;
        logic stall;
        logic resume;
        logic in1_nak_ctrl;
        logic out1_nak;
        logic out2_nak;
        logic dma_end_en;
        logic dma_en;
        logic dma_masked;
        logic rwake;
        logic dend;
        logic dma_fill;
        logic dma_req;
        logic cpu_bank_sel;
        logic wait_q;
        logic [31:0] rdata;
    } ufh_st_t;
    ufh_st_t st_q, st_d;

    // ======================================================
    // Bank counters
    // ======================================================
    logic [6:0] cpu_cnt, sie_cnt;
    logic cpu_full, sie_full;
    logic fifo_clr, swap, wr_byte, dend_wr;

    assign wr_byte = i_cpu_wr | i_dma_wr;

    ufh_bank_ctr #(.DEPTH(UFH_BANK_BYTES)) u_cpu_bank (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_clr(fifo_clr | swap),
        .i_inc(wr_byte),
        .i_load(1'b0),
        .i_load_val(UFH_CNT_ZERO),
        .i_dec(1'b0),
        .o_cnt(cpu_cnt),
        .o_full(cpu_full)
    );

    ufh_bank_ctr #(.DEPTH(UFH_BANK_BYTES)) u_sie_bank (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_clr(fifo_clr | (i_tx_done & ~swap)),
        .i_inc(1'b0),
        .i_load(swap),
        .i_load_val(cpu_cnt),
        .i_dec(i_tx_byte & st_q.in1_nak_ctrl),
        .o_cnt(sie_cnt),
        .o_full(sie_full)
    );

    // ======================================================
    // Bus decode and bank swap
    // ======================================================
    logic wr_acc, rd_acc, cpu_done, sie_busy, stall_wr_ok;
    // Writes land at the edge where waitrequest is low; read data is
    // captured in the wait cycle so that it stands at that same edge
    assign wr_acc = avs_write & st_q.wait_q;
    assign rd_acc = avs_read & ~st_q.wait_q;
    assign dend_wr = wr_acc && avs_address == UFH_A_IN1_CTRL &&
                     avs_writedata[UFH_B_DEND];
    assign fifo_clr = wr_acc && avs_address == UFH_A_IN1_CTRL &&
                      avs_writedata[UFH_B_FIFO_CLR];
    // Firmware STALL counts only inside a firmware-executed request
    assign stall_wr_ok = i_fw_req_active |
                         ~avs_writedata[UFH_B_STALL];
    // Bank is busy until its data is sent correctly
    assign sie_busy = st_q.in1_nak_ctrl;
    // DMA fill without end enable waits for data-end
    assign cpu_done = st_q.dend | dend_wr |
                      (cpu_full & ~(st_q.dma_fill & ~st_q.dma_end_en));
    assign swap = cpu_done && sie_cnt == UFH_CNT_ZERO && !sie_busy &&
                  !fifo_clr;

    always_comb begin
        st_d = st_q;
        st_d.wait_q = (avs_read | avs_write) & ~st_q.wait_q;
        // Register writes land in the cycle in which waitrequest is low
        if (wr_acc) begin
            unique case (avs_address)
                UFH_A_NAK_MASK: begin
                    st_d.nak_mask = avs_writedata[7:0];
                end
                UFH_A_EP_NAK: begin
                    if (st_q.nak_mask[UFH_B_OUT2]) begin
                        st_d.out2_nak = avs_writedata[UFH_B_OUT2];
                    end
                    if (st_q.nak_mask[UFH_B_OUT1]) begin
                        st_d.out1_nak = avs_writedata[UFH_B_OUT1];
                    end
                end
                UFH_A_SIE_CTRL: begin
                    if (stall_wr_ok) begin
                        st_d.stall = avs_writedata[UFH_B_STALL];
                    end
                    if (st_q.rwake) begin
                        st_d.resume = avs_writedata[UFH_B_RESUME];
                    end
                end
                UFH_A_IN1_CTRL: begin
                    st_d.dma_end_en = avs_writedata[UFH_B_DMA_END_EN];
                    st_d.dma_en = avs_writedata[UFH_B_DMA_EN];
                    st_d.rwake = avs_writedata[UFH_B_RWAKE];
                    if (avs_writedata[UFH_B_DMA_UNMASK]) begin
                        st_d.dma_masked = 1'b0;
                    end
                    if (avs_writedata[UFH_B_DEND]) begin
                        st_d.dend = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Hardware STALL set wins over clear by SETUP and firmware
        if (i_setup_token) begin
            st_d.stall = 1'b0;
        end
        if (i_bad_wvalue | i_auto_overrun) begin
            st_d.stall = 1'b1;
        end
        // Track whether DMA or the CPU is filling the CPU-side bank
        if (i_dma_wr) begin
            st_d.dma_fill = 1'b1;
        end
        if (i_cpu_wr && cpu_cnt == UFH_CNT_ZERO) begin
            st_d.dma_fill = 1'b0;
        end
        // Acknowledged packet frees the serial-engine bank
        if (i_tx_done && st_q.in1_nak_ctrl) begin
            st_d.in1_nak_ctrl = 1'b0;
        end
        // DMA request
        if (st_q.dma_en && !st_q.dma_masked && !cpu_full) begin
            st_d.dma_req = 1'b1;
        end
        if (i_dma_wr && cpu_cnt == 7'(UFH_BANK_BYTES - 1)) begin
            st_d.dma_req = 1'b0;
        end
        // Swap moves the CPU bank count to the serial-engine side
        if (swap) begin
            st_d.in1_nak_ctrl = 1'b1;
            st_d.cpu_bank_sel = ~st_q.cpu_bank_sel;
            st_d.dend = 1'b0;
            st_d.dma_fill = 1'b0;
            st_d.dma_req = st_q.dma_en & ~st_q.dma_masked;
        end
        if (i_dma_tc && st_q.dma_en) begin
            st_d.dma_req = 1'b0;
            st_d.dma_masked = 1'b1;
        end
        // No request may stand while DMA is off
        if (!st_d.dma_en) begin
            st_d.dma_req = 1'b0;
        end
        // FIFO clear discards both banks and any pending data-end
        if (fifo_clr) begin
            st_d.in1_nak_ctrl = 1'b0;
            st_d.dend = 1'b0;
        end
        // Losing remote wakeup enable also ends Resume signalling
        if (!st_q.rwake && !(wr_acc && avs_address == UFH_A_IN1_CTRL &&
            avs_writedata[UFH_B_RWAKE])) begin
            st_d.resume = 1'b0;
        end
        // Read data
        if (rd_acc) begin
            unique case (avs_address)
                UFH_A_NAK_MASK: st_d.rdata = {24'h0, st_q.nak_mask};
                UFH_A_SIE_CTRL: st_d.rdata = {28'h0, st_q.stall, 2'b00,
                                              st_q.resume};
                UFH_A_EP_NAK: st_d.rdata = {28'h0, st_q.out2_nak,
                                            st_q.out1_nak, 1'b0,
                                            st_q.in1_nak_ctrl};
                UFH_A_IN1_CTRL: st_d.rdata = {26'h0, st_q.rwake, 1'b0,
                                              ~st_q.dma_masked, st_q.dma_en,
                                              st_q.dma_end_en, st_q.dend};
                UFH_A_IN1_STAT: st_d.rdata = {16'h0, 1'b0, sie_cnt,
                                              st_q.dma_req, cpu_cnt};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================
    // Outputs
    // ======================================================
    assign avs_waitrequest = (avs_read | avs_write) & ~st_q.wait_q;
    assign avs_readdata = st_q.rdata;
    assign o_dma_req = st_q.dma_req;
    assign o_in1_send = i_in_token & st_q.in1_nak_ctrl;
    assign o_in1_nak = ~st_q.in1_nak_ctrl;
    assign o_ep0_stall = st_q.stall;
    assign o_resume = st_q.resume;
    assign o_out1_nak = st_q.out1_nak;
    assign o_out2_nak = st_q.out2_nak;

    // ======================================================
    // Assertions
    // ======================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    send_needs_nakctl_a: assert property (
        o_in1_send |-> o_in1_nak == 1'b0)
        else $error("IN data sent while NAK control clear");
    swap_sets_nakctl_a: assert property (
        swap |=> st_q.in1_nak_ctrl)
        else $error("swap did not set NAK control");
    swap_needs_empty_a: assert property (
        swap |-> sie_cnt == UFH_CNT_ZERO)
        else $error("swap with busy serial bank");
    clr_drops_nakctl_a: assert property (
        fifo_clr |=> !st_q.in1_nak_ctrl)
        else $error("FIFO clear left NAK control set");
    tc_masks_dma_a: assert property (
        i_dma_tc && st_q.dma_en |=> !o_dma_req && st_q.dma_masked)
        else $error("terminal count did not mask DMA");
    setup_clr_stall_a: assert property (
        i_setup_token && !i_bad_wvalue && !i_auto_overrun
        |=> !o_ep0_stall)
        else $error("SETUP did not clear STALL");
    hw_stall_set_a: assert property (
        i_bad_wvalue |=> o_ep0_stall)
        else $error("hardware STALL not set");
    resume_guard_a: assert property (
        $rose(o_resume) |-> st_q.rwake)
        else $error("Resume rose without wakeup enable");
    mask_hold_a: assert property (
        wr_acc && avs_address == UFH_A_EP_NAK
        && !st_q.nak_mask[UFH_B_OUT1] |=> $stable(o_out1_nak))
        else $error("masked OUT NAK bit changed");
    dma_full_drop_a: assert property (
        i_dma_wr && !swap && cpu_cnt == 7'(UFH_BANK_BYTES - 1)
        |=> !o_dma_req)
        else $error("DMA request stayed after 64 bytes");

    // Endpoint 1 flow, DMA request and OUT2 NAK mask
    nakctl_fall_a: assert property (
        $fell(st_q.in1_nak_ctrl) |-> $past(i_tx_done) || $past(fifo_clr))
        else $error("NAK control cleared without cause");
    dend_swap_a: assert property (
        dend_wr && !fifo_clr && sie_cnt == UFH_CNT_ZERO
        && !st_q.in1_nak_ctrl |=> st_q.in1_nak_ctrl)
        else $error("data-end did not start the short packet");
    dma_rearm_a: assert property (
        swap && st_q.dma_en && !st_q.dma_masked && !i_dma_tc
        && !(wr_acc && avs_address == UFH_A_IN1_CTRL) |=> o_dma_req)
        else $error("DMA request not rearmed at swap");
    out2_rise_a: assert property (
        $rose(o_out2_nak) |-> $past(wr_acc)
        && $past(avs_address) == UFH_A_EP_NAK
        && $past(st_q.nak_mask[UFH_B_OUT2]))
        else $error("OUT NAK bit rose through a masked write");

    // Endpoint 0 STALL and Resume
    fw_stall_gate_a: assert property (
        wr_acc && avs_address == UFH_A_SIE_CTRL && !i_fw_req_active
        && !st_q.stall && !i_bad_wvalue && !i_auto_overrun
        |=> !o_ep0_stall)
        else $error("firmware STALL taken outside its request");
    stall_hold_a: assert property (
        o_ep0_stall && !i_setup_token
        && !(wr_acc && avs_address == UFH_A_SIE_CTRL) |=> o_ep0_stall)
        else $error("STALL dropped without SETUP or write");
    resume_hold_a: assert property (
        o_resume && st_q.rwake
        && !(wr_acc && avs_address == UFH_A_SIE_CTRL) |=> o_resume)
        else $error("Resume dropped while its bit was set");

    // ======================================================
    // Cover points
    // ======================================================
    swap_c: cover property (swap);
    short_pkt_c: cover property (dend_wr && swap);
    tc_c: cover property (i_dma_tc && st_q.dma_en);
    stall_c: cover property (o_ep0_stall ##1 i_setup_token);
    dma_hold_c: cover property (cpu_full && st_q.dma_fill
        && !st_q.dma_end_en);
endmodule

// *** tb/ufh_host_model.sv ***
// Host-side model: IN and SETUP tokens toward the block
`timescale 1ns/1ns
module ufh_host_model (
    input wire logic i_core_clk, // Clock
    input wire logic i_in1_send, // Block sends endpoint 1 data
    output logic o_in_token, // IN token
    output logic o_tx_byte, // One byte taken from the block
    output logic o_tx_done, // Packet acknowledged
    output logic o_setup_token // SETUP token on endpoint 0
);
    initial begin
        o_in_token = 1'b0;
        o_tx_byte = 1'b0;
        o_tx_done = 1'b0;
        o_setup_token = 1'b0;
    end
    // ==========
    // Transactions
    // Data is taken only when the block answers the token with data
    task automatic in_xfer(input int n, output logic sent);
        @(posedge i_core_clk);
        o_in_token <= 1'b1;
        @(posedge i_core_clk);
        sent = i_in1_send;
        o_in_token <= 1'b0;
        if (sent === 1'b1) begin
            repeat (n) begin
                @(posedge i_core_clk);
                o_tx_byte <= 1'b1;
            end
            @(posedge i_core_clk);
            o_tx_byte <= 1'b0;
            o_tx_done <= 1'b1;
            @(posedge i_core_clk);
            o_tx_done <= 1'b0;
        end
    endtask
    task automatic setup();
        @(posedge i_core_clk);
        o_setup_token <= 1'b1;
        @(posedge i_core_clk);
        o_setup_token <= 1'b0;
    endtask
endmodule

// *** tb/tb_ufh_ctrl.sv ***
// Testbench: register, bulk IN, DMA, STALL and Resume checks
`timescale 1ns/1ns
module tb_ufh_ctrl;
    import ufh_pkg::*;
    logic i_core_clk, i_arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic i_cpu_wr, i_dma_wr, i_dma_tc, i_in_token, i_tx_byte, i_tx_done;
    logic i_setup_token, i_bad_wvalue, i_auto_overrun, i_fw_req_active;
    logic i_ep0_wr, o_dma_req, o_in1_send, o_in1_nak, o_ep0_stall;
    logic o_resume, o_out1_nak, o_out2_nak, s;
    int num_errors, comparisons;
    int cycles = 0;
    ufh_ctrl ufh_ctrl_inst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .i_cpu_wr(i_cpu_wr), .i_dma_wr(i_dma_wr), .i_dma_tc(i_dma_tc),
        .i_in_token(i_in_token), .i_tx_byte(i_tx_byte),
        .i_tx_done(i_tx_done), .i_setup_token(i_setup_token),
        .i_bad_wvalue(i_bad_wvalue), .i_auto_overrun(i_auto_overrun),
        .i_fw_req_active(i_fw_req_active), .i_ep0_wr(i_ep0_wr),
        .o_dma_req(o_dma_req), .o_in1_send(o_in1_send),
        .o_in1_nak(o_in1_nak), .o_ep0_stall(o_ep0_stall),
        .o_resume(o_resume), .o_out1_nak(o_out1_nak),
        .o_out2_nak(o_out2_nak));
    ufh_host_model ufh_host_model_inst (.i_core_clk(i_core_clk),
        .i_in1_send(o_in1_send), .o_in_token(i_in_token),
        .o_tx_byte(i_tx_byte), .o_tx_done(i_tx_done),
        .o_setup_token(i_setup_token));
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    // ==========
    // Checking and bus tasks
    task automatic stop_test();
        $display("compares %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        check_reg({31'h0, got}, {31'h0, exp});
    endtask
    // Request holds until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge i_core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge i_core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check_reg(q, exp);
    endtask
    task automatic wait_pin(input int sel, input logic exp);
        logic v;
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            v = (sel == 0) ? o_dma_req : (sel == 1) ? o_ep0_stall : o_resume;
            n++;
        end while (v !== exp && n < 16);
        check_pin(v, exp);
    endtask
    task automatic push(input logic dma, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            i_cpu_wr <= !dma;
            i_dma_wr <= dma;
        end
        @(posedge i_core_clk);
        i_cpu_wr <= 1'b0;
        i_dma_wr <= 1'b0;
    endtask
    task automatic pulse(input int sel);
        @(posedge i_core_clk);
        i_dma_tc <= (sel == 0);
        i_bad_wvalue <= (sel == 1);
        i_auto_overrun <= (sel == 2);
        @(posedge i_core_clk);
        {i_dma_tc, i_bad_wvalue, i_auto_overrun} <= 3'h0;
    endtask
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // ==========
    // Test sequence
    initial begin
        {i_arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {i_cpu_wr, i_dma_wr, i_dma_tc, i_bad_wvalue, i_auto_overrun} = '0;
        {i_fw_req_active, i_ep0_wr, num_errors, comparisons} = '0;
        repeat (4) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        rdc(UFH_A_NAK_MASK, 32'h0);
        check_pin(o_in1_nak, 1'b1);
        rdc(UFH_A_SIE_CTRL, 32'h0);
        rdc(UFH_A_EP_NAK, 32'h0);
        wr(4'hf, 8'hff);
        rdc(4'hf, 32'h0);
        $display("test reset done");
        wr(UFH_A_EP_NAK, 8'h0c);
        rdc(UFH_A_EP_NAK, 32'h0);
        wr(UFH_A_NAK_MASK, 8'h04);
        rdc(UFH_A_NAK_MASK, 32'h04);
        wr(UFH_A_EP_NAK, 8'h0c);
        rdc(UFH_A_EP_NAK, 32'h04);
        check_pin(o_out1_nak, 1'b1);
        check_pin(o_out2_nak, 1'b0);
        wr(UFH_A_NAK_MASK, 8'h0c);
        wr(UFH_A_EP_NAK, 8'h08);
        rdc(UFH_A_EP_NAK, 32'h08);
        check_pin(o_out2_nak, 1'b1);
        wr(UFH_A_EP_NAK, 8'h00);
        $display("test nak mask done");
        ufh_host_model_inst.in_xfer(4, s);
        check_pin(s, 1'b0);
        push(1'b0, 64);
        rdc(UFH_A_EP_NAK, 32'h01);
        rdc(UFH_A_IN1_STAT, 32'h4000);
        check_pin(o_in1_nak, 1'b0);
        ufh_host_model_inst.in_xfer(64, s);
        check_pin(s, 1'b1);
        rdc(UFH_A_EP_NAK, 32'h0);
        push(1'b0, 3);
        wr(UFH_A_IN1_CTRL, 8'h01);
        rdc(UFH_A_IN1_STAT, 32'h0300);
        rdc(UFH_A_EP_NAK, 32'h01);
        push(1'b0, 64);
        rdc(UFH_A_IN1_STAT, 32'h0340);
        ufh_host_model_inst.in_xfer(3, s);
        rdc(UFH_A_IN1_STAT, 32'h4000);
        wr(UFH_A_IN1_CTRL, 8'h10);
        rdc(UFH_A_EP_NAK, 32'h0);
        rdc(UFH_A_IN1_STAT, 32'h0);
        $display("test bulk in done");
        push(1'b0, 1);
        wr(UFH_A_IN1_CTRL, 8'h0c);
        wait_pin(0, 1'b1);
        push(1'b1, 63);
        wait_pin(0, 1'b0);
        rdc(UFH_A_IN1_STAT, 32'h0040);
        rdc(UFH_A_EP_NAK, 32'h0);
        wr(UFH_A_IN1_CTRL, 8'h05);
        wait_pin(0, 1'b1);
        rdc(UFH_A_IN1_STAT, 32'h4080);
        pulse(0);
        wait_pin(0, 1'b0);
        ufh_host_model_inst.in_xfer(64, s);
        rdc(UFH_A_IN1_STAT, 32'h0);
        wr(UFH_A_IN1_CTRL, 8'h0c);
        wait_pin(0, 1'b1);
        wr(UFH_A_IN1_CTRL, 8'h10);
        $display("test dma done");
        i_fw_req_active <= 1'b1;
        wr(UFH_A_SIE_CTRL, 8'h08);
        wait_pin(1, 1'b1);
        ufh_host_model_inst.setup();
        i_fw_req_active <= 1'b0;
        rdc(UFH_A_SIE_CTRL, 32'h0);
        wr(UFH_A_SIE_CTRL, 8'h08);
        rdc(UFH_A_SIE_CTRL, 32'h0);
        pulse(1);
        wait_pin(1, 1'b1);
        ufh_host_model_inst.setup();
        wait_pin(1, 1'b0);
        pulse(2);
        wait_pin(1, 1'b1);
        ufh_host_model_inst.setup();
        wait_pin(1, 1'b0);
        $display("test stall done");
        wr(UFH_A_SIE_CTRL, 8'h01);
        rdc(UFH_A_SIE_CTRL, 32'h0);
        check_pin(o_resume, 1'b0);
        wr(UFH_A_IN1_CTRL, 8'h20);
        wr(UFH_A_SIE_CTRL, 8'h01);
        wait_pin(2, 1'b1);
        repeat (20) @(posedge i_core_clk);
        check_pin(o_resume, 1'b1);
        wr(UFH_A_SIE_CTRL, 8'h00);
        wait_pin(2, 1'b0);
        $display("test resume done");
        stop_test();
    end
endmodule
